//--- eqc_equalizer_control.sv
// equalizer control: mode pins, sleep control and serial registers
`timescale 1ns/10ps
module eqc_equalizer_control
   import eqc_pkg::*;
#(
   parameter int unsigned PD_CYCLES_P = PD_CYCLES,
   parameter int CNT_W = 16
)
(
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // serial port
   input wire logic sck,
   input wire logic ss_n,
   input wire logic mosi,
   output logic miso,
   output logic miso_oe,
   // mode pins
   input wire logic spi_en,
   input wire logic bypass,
   input wire logic mute,
   input wire logic auto_sleep,
   // signal path status
   input wire logic signal_detect,
   input wire logic [4:0] cable_length,
   input wire logic [1:0] equalized_in,
   // signal path control
   output logic carrier_present_n,
   output logic [1:0] equalized_output_pair,
   output logic filter_en,
   output logic dc_restore_en,
   output logic output_muted,
   output logic powered_down,
   // driver and launch settings
   output logic [2:0] output_swing,
   output logic [2:0] offset_voltage,
   output logic launch_coarse,
   output logic [3:0] launch_fine,
   output logic extended_reach
);
   localparam int WAKE_LIM = WAKE_CYCLES;
   localparam logic [CNT_W-1:0] PD_LIM = PD_CYCLES_P[CNT_W-1:0];

   eqc_reg_if bus ();

   logic [11:0] sync_a;
   logic [11:0] sync_b;
   logic spi_mode;
   logic bypass_s;
   logic mute_s;
   logic auto_s;
   logic sig_s;
   logic [1:0] data_s;
   logic [4:0] cable_s;

   logic [7:0] gen_ctl;
   logic [7:0] driver;
   logic [7:0] launch;
   logic [7:0] aux;

   eqc_power_type state;
   eqc_power_type next_state;
   logic [CNT_W-1:0] drain_cnt;

   //------------------------------------------------------------------
   // serial port
   //------------------------------------------------------------------
   eqc_spi_slave u_spi (
      .clk(clk),
      .resetn(resetn),
      .sck(sck),
      .ss_n(ss_n),
      .mosi(mosi),
      .miso(miso),
      .miso_oe(miso_oe),
      .regs(bus.port)
   );

   //------------------------------------------------------------------
   // pin synchronisers
   //------------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sync_a <= 12'h000;
         sync_b <= 12'h000;
      end else begin
         sync_a <= {cable_length, equalized_in, signal_detect, auto_sleep, mute, bypass, spi_en};
         sync_b <= sync_a;
      end
   end
   assign spi_mode = sync_b[0];
   assign bypass_s = sync_b[1];
   assign mute_s = sync_b[2];
   assign auto_s = sync_b[3];
   assign sig_s = sync_b[4];
   assign data_s = sync_b[6:5];
   assign cable_s = sync_b[11:7];

   //------------------------------------------------------------------
   // register file
   //------------------------------------------------------------------
   logic wr_gen;
   logic wr_drv;
   logic wr_lau;
   logic wr_aux;
   assign wr_gen = bus.wr_en && (bus.addr == ADDR_GENERAL);
   assign wr_drv = bus.wr_en && (bus.addr == ADDR_DRIVER);
   assign wr_lau = bus.wr_en && (bus.addr == ADDR_LAUNCH);
   assign wr_aux = bus.wr_en && (bus.addr == ADDR_AUX);

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         gen_ctl <= GENERAL_RST;
         driver <= DRIVER_RST;
         launch <= LAUNCH_RST;
         aux <= AUX_RST;
      end else begin
         if (wr_gen) begin
            gen_ctl <= {1'b0, bus.wdata[6:2], 2'h0};
         end
         if (wr_drv) begin
            driver <= {bus.wdata[7:2], 2'h0};
         end
         if (wr_lau) begin
            launch <= {bus.wdata[7:3], 3'h0};
         end
         if (wr_aux) begin
            aux <= bus.wdata;
         end
      end
   end

   // read side: carrier flag and cable length are live status
   logic [7:0] gen_rd;
   assign gen_rd = {sig_s, gen_ctl[6:0]};
   assign bus.rdata = (bus.addr == ADDR_GENERAL) ? gen_rd :
                      (bus.addr == ADDR_DRIVER) ? driver :
                      (bus.addr == ADDR_LAUNCH) ? launch :
                      (bus.addr == ADDR_CABLE) ? {cable_s, 3'h0} :
                      (bus.addr == ADDR_AUX) ? aux : 8'h00;

   assign output_swing = driver[7:5];
   assign offset_voltage = driver[4:2];
   assign launch_coarse = launch[7];
   assign launch_fine = launch[6:3];
   assign extended_reach = gen_ctl[GEN_EXT_BIT];

   //------------------------------------------------------------------
   // mode selection
   //------------------------------------------------------------------
   logic [1:0] sleep_field;
   logic mute_req;
   logic bypass_req;
   logic sleep_auto;
   logic sleep_force;
   logic asleep;
   assign sleep_field = gen_ctl[GEN_SLEEP_HI:GEN_SLEEP_LO];
   assign mute_req = spi_mode ? gen_ctl[GEN_MUTE_BIT] : mute_s;
   assign bypass_req = spi_mode ? gen_ctl[GEN_BYPASS_BIT] : bypass_s;
   assign sleep_auto = spi_mode ? (sleep_field == SLEEP_AUTO) : auto_s;
   assign sleep_force = spi_mode && (sleep_field == SLEEP_FORCE);
   assign asleep = (state == PWR_ASLEEP);

   //------------------------------------------------------------------
   // power state machine
   //------------------------------------------------------------------
   always_comb begin
      next_state = state;
      case (state)
         PWR_ON: begin
            if (sleep_force) begin
               next_state = PWR_ASLEEP;
            end else if (sleep_auto && !sig_s) begin
               next_state = PWR_DRAIN;
            end
         end
         PWR_DRAIN: begin
            if (sleep_force) begin
               next_state = PWR_ASLEEP;
            end else if (!sleep_auto || sig_s) begin
               next_state = PWR_ON;
            end else if (drain_cnt == PD_LIM) begin
               next_state = PWR_ASLEEP;
            end
         end
         PWR_ASLEEP: begin
            if (!sleep_force && (!sleep_auto || sig_s)) begin
               next_state = PWR_ON;
            end
         end
         default: begin
            next_state = PWR_ON;
         end
      endcase
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state <= PWR_ON;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         drain_cnt <= '0;
      end else if (state == PWR_DRAIN) begin
         drain_cnt <= drain_cnt + {{(CNT_W-1){1'b0}}, 1'b1};
      end else begin
         drain_cnt <= '0;
      end
   end

   //------------------------------------------------------------------
   // signal path controls
   //------------------------------------------------------------------
   logic next_path_en;
   logic next_muted;
   logic [1:0] next_pair;
   assign next_path_en = !asleep && !(bypass_req && !mute_req);
   assign next_muted = !asleep && mute_req;
   assign next_pair = (asleep || mute_req) ? 2'h0 : data_s;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         filter_en <= 1'b0;
         dc_restore_en <= 1'b0;
         output_muted <= 1'b0;
         powered_down <= 1'b0;
         equalized_output_pair <= 2'h0;
      end else begin
         filter_en <= next_path_en;
         dc_restore_en <= next_path_en;
         output_muted <= next_muted;
         powered_down <= asleep;
         equalized_output_pair <= next_pair;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         carrier_present_n <= 1'b1;
      end else begin
         carrier_present_n <= !sig_s;
      end
   end

   //------------------------------------------------------------------
   // checks
   //------------------------------------------------------------------
   property p_bypass_filter;
      @(posedge clk) disable iff (!resetn)
         (bypass_req && !mute_req && !asleep) |=> !filter_en;
   endproperty
   a_bypass_filter: assert property (p_bypass_filter) else $error("filter on in bypass");

   property p_bypass_dc;
      @(posedge clk) disable iff (!resetn)
         (!bypass_req && !asleep) |=> (dc_restore_en && filter_en);
   endproperty
   a_bypass_dc: assert property (p_bypass_dc) else $error("restore off without bypass");

   property p_cd_high;
      @(posedge clk) disable iff (!resetn) !sig_s |=> carrier_present_n;
   endproperty
   a_cd_high: assert property (p_cd_high) else $error("carrier flag low, no signal");

   property p_cd_low;
      @(posedge clk) disable iff (!resetn) $rose(sig_s) |=> !carrier_present_n;
   endproperty
   a_cd_low: assert property (p_cd_low) else $error("carrier flag high with signal");

   property p_mute_zero;
      @(posedge clk) disable iff (!resetn)
         mute_req |=> (equalized_output_pair == 2'h0);
   endproperty
   a_mute_zero: assert property (p_mute_zero) else $error("output live while muted");

   property p_mute_pass;
      @(posedge clk) disable iff (!resetn)
         (!mute_req && !asleep) |=> (equalized_output_pair == $past(data_s));
   endproperty
   a_mute_pass: assert property (p_mute_pass) else $error("output not passing data");

   property p_enter_drain;
      @(posedge clk) disable iff (!resetn)
         (state == PWR_ON && sleep_auto && !sig_s && !sleep_force) |=> (state == PWR_DRAIN);
   endproperty
   a_enter_drain: assert property (p_enter_drain) else $error("no power down on loss");

   property p_drain_bound;
      @(posedge clk) disable iff (!resetn) (state == PWR_DRAIN) |-> (drain_cnt <= PD_LIM);
   endproperty
   a_drain_bound: assert property (p_drain_bound) else $error("power down too slow");

   property p_wake;
      @(posedge clk) disable iff (!resetn)
         (asleep && sig_s && sleep_auto && !sleep_force) |-> ##[1:WAKE_LIM] !powered_down;
   endproperty
   a_wake: assert property (p_wake) else $error("wake too slow");

   property p_no_auto;
      @(posedge clk) disable iff (!resetn)
         (!sleep_auto && !sleep_force) |=> (state == PWR_ON);
   endproperty
   a_no_auto: assert property (p_no_auto) else $error("sleep with auto sleep off");

   property p_force;
      @(posedge clk) disable iff (!resetn) sleep_force |=> asleep ##1 powered_down;
   endproperty
   a_force: assert property (p_force) else $error("forced sleep not taken");

   property p_sleep_first;
      @(posedge clk) disable iff (!resetn)
         asleep |=> (!filter_en && !output_muted && equalized_output_pair == 2'h0);
   endproperty
   a_sleep_first: assert property (p_sleep_first) else $error("path active while asleep");

   property p_mute_over_bypass;
      @(posedge clk) disable iff (!resetn)
         (mute_req && bypass_req && !asleep) |=> (filter_en && output_muted);
   endproperty
   a_mute_over_bypass: assert property (p_mute_over_bypass) else $error("bypass won");

   property p_pin_mode;
      @(posedge clk) disable iff (!resetn)
         (!spi_mode && !asleep && mute_s) |=> output_muted;
   endproperty
   a_pin_mode: assert property (p_pin_mode) else $error("mute pin ignored");

   property p_reg_write;
      @(posedge clk) disable iff (!resetn) wr_aux |=> (aux == $past(bus.wdata));
   endproperty
   a_reg_write: assert property (p_reg_write) else $error("register not written");

endmodule // eqc_equalizer_control

//--- eqc_pkg.sv
// constants and types shared by the equalizer control block
//----------------------------------------------------------------------
// Summary of operation
//----------------------------------------------------------------------
//----------------------------------------------------------------------
package eqc_pkg;
   // register addresses
   localparam int ADDR_W = 7;
   localparam int DATA_W = 8;
   localparam logic [6:0] ADDR_GENERAL = 7'h00;
   localparam logic [6:0] ADDR_DRIVER = 7'h01;
   localparam logic [6:0] ADDR_LAUNCH = 7'h02;
   localparam logic [6:0] ADDR_CABLE = 7'h03;
   localparam logic [6:0] ADDR_AUX = 7'h04;
   // general control field positions
   localparam int GEN_CD_BIT = 7;
   localparam int GEN_MUTE_BIT = 6;
   localparam int GEN_BYPASS_BIT = 5;
   localparam int GEN_SLEEP_HI = 4;
   localparam int GEN_SLEEP_LO = 3;
   localparam int GEN_EXT_BIT = 2;
   // reset values
   localparam logic [7:0] GENERAL_RST = 8'h08;
   localparam logic [7:0] DRIVER_RST = 8'h64;
   localparam logic [7:0] LAUNCH_RST = 8'h00;
   localparam logic [7:0] AUX_RST = 8'h00;
   // sleep field codes
   localparam logic [1:0] SLEEP_OFF = 2'h0;
   localparam logic [1:0] SLEEP_AUTO = 2'h1;
   localparam logic [1:0] SLEEP_FORCE = 2'h2;
   // serial frame
   localparam logic [4:0] CMD_BITS = 5'h08;
   localparam logic [4:0] FRAME_BITS = 5'h10;
   // timing
   localparam int CLK_MHZ = 100;
   localparam int PD_TIME_US = 200;
   localparam int PIPE_MARGIN = 8;
   localparam int PD_CYCLES = PD_TIME_US * CLK_MHZ - PIPE_MARGIN;
   localparam int WAKE_TIME_US = 1;
   localparam int WAKE_CYCLES = WAKE_TIME_US * CLK_MHZ;
   // power state
   typedef enum logic [1:0] {PWR_ON, PWR_DRAIN, PWR_ASLEEP} eqc_power_type;
endpackage

//--- eqc_reg_if.sv
// register access carrier between serial port and register file
`timescale 1ns/10ps
interface eqc_reg_if;
   logic wr_en;
   logic [eqc_pkg::ADDR_W-1:0] addr;
   logic [eqc_pkg::DATA_W-1:0] wdata;
   logic [eqc_pkg::DATA_W-1:0] rdata;
   modport port (output wr_en, output addr, output wdata, input rdata);
   modport regs (input wr_en, input addr, input wdata, output rdata);
endinterface

//--- eqc_spi_slave.sv
// serial port slave: frame decode, write strobe, read shift out
`timescale 1ns/10ps
module eqc_spi_slave
   import eqc_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // serial pins
   input wire logic sck,
   input wire logic ss_n,
   input wire logic mosi,
   output logic miso,
   output logic miso_oe,
   // register access
   eqc_reg_if.port regs
);
   logic [2:0] sck_s;
   logic [1:0] ss_s;
   logic [1:0] mosi_s;
   logic [4:0] bit_cnt;
   logic [14:0] shift;
   logic reading;
   logic [7:0] tx;
   logic active;
   logic sck_rise;
   logic sck_fall;
   logic last_bit;
   logic cmd_done;
   logic wr_frame;
   assign active = !ss_s[1];
   assign sck_rise = sck_s[1] && !sck_s[2];
   assign sck_fall = !sck_s[1] && sck_s[2];
   assign last_bit = active && sck_rise && (bit_cnt == FRAME_BITS - 5'h01);
   assign cmd_done = active && sck_rise && (bit_cnt == CMD_BITS - 5'h01);
   //------------------------------------------------------------------
   // pin synchronisers
   //------------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sck_s <= 3'h0;
         ss_s <= 2'h3;
         mosi_s <= 2'h0;
      end else begin
         sck_s <= {sck_s[1:0], sck};
         ss_s <= {ss_s[0], ss_n};
         mosi_s <= {mosi_s[0], mosi};
      end
   end
   //------------------------------------------------------------------
   // receive shifter
   //------------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         bit_cnt <= 5'h00;
         shift <= 15'h0000;
      end else if (!active) begin
         bit_cnt <= 5'h00;
      end else if (sck_rise) begin
         shift <= {shift[13:0], mosi_s[1]};
         bit_cnt <= (bit_cnt == FRAME_BITS) ? bit_cnt : bit_cnt + 5'h01;
      end
   end
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         regs.wr_en <= 1'b0;
         regs.addr <= 7'h00;
         regs.wdata <= 8'h00;
         reading <= 1'b0;
      end else begin
         regs.wr_en <= last_bit && !shift[14];
         reading <= active && (reading || (cmd_done && shift[6]));
         if (cmd_done && shift[6]) begin
            regs.addr <= {shift[5:0], mosi_s[1]};
         end else if (last_bit) begin
            regs.addr <= shift[13:7];
            regs.wdata <= {shift[6:0], mosi_s[1]};
         end
      end
   end
   //------------------------------------------------------------------
   // read data out, msb first from the eighth falling edge
   //------------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         miso <= 1'b0;
         miso_oe <= 1'b0;
         tx <= 8'h00;
      end else if (!reading) begin
         miso_oe <= 1'b0;
      end else if (sck_fall) begin
         miso_oe <= 1'b1;
         miso <= miso_oe ? tx[7] : regs.rdata[7];
         tx <= miso_oe ? {tx[6:0], 1'b0} : {regs.rdata[6:0], 1'b0};
      end
   end
   // checker helper: frame kind taken from its first bit
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wr_frame <= 1'b0;
      end else if (active && sck_rise && (bit_cnt == 5'h00)) begin
         wr_frame <= !mosi_s[1];
      end
   end
   property p_write_quiet;
      @(posedge clk) disable iff (!resetn)
         (active && wr_frame && (bit_cnt != 5'h00)) |-> !miso_oe;
   endproperty
   a_write_quiet: assert property (p_write_quiet) else $error("miso driven in write");
   property p_read_start;
      @(posedge clk) disable iff (!resetn)
         (reading && sck_fall && !miso_oe) |=> (miso_oe && miso == $past(regs.rdata[7]));
   endproperty
   a_read_start: assert property (p_read_start) else $error("read data not started");
   property p_full_frame;
      @(posedge clk) disable iff (!resetn) regs.wr_en |-> $past(bit_cnt) == FRAME_BITS - 5'h01;
   endproperty
   a_full_frame: assert property (p_full_frame) else $error("write from short frame");
endmodule // eqc_spi_slave

//--- eqc_spi_host.sv
// serial host model that drives frames into the equalizer control block
`timescale 1ns/10ps
module eqc_spi_host (
   // clock
   input wire logic clk,
   // serial pins
   output logic sck,
   output logic ss_n,
   output logic mosi,
   input wire logic miso,
   input wire logic miso_oe
);
   logic in_write;
   logic oe_in_write;

   initial begin
      sck = 1'b0;
      ss_n = 1'b1;
      mosi = 1'b0;
      in_write = 1'b0;
      oe_in_write = 1'b0;
   end

   // half a serial clock period: 8 cycles of the 100 MHz clock
   task automatic half();
      repeat (8) @(posedge clk);
      #1;
   endtask

   // one frame of nbits, msb first; rd collects miso after the eighth bit
   task automatic xfer(input logic [15:0] word, input int nbits, output logic [7:0] rd);
      logic rdf;
      rdf = word[15];
      rd = 8'h00;
      in_write = !rdf;
      ss_n = 1'b0;
      for (int i = 0; i < nbits; i++) begin
         if (rdf && i >= 8) begin
            mosi = ~mosi;
         end else begin
            mosi = word[15 - i];
         end
         half();
         sck = 1'b1;
         if (i >= 8) begin
            // released miso reads as the inverse of its last level
            rd = {rd[6:0], miso_oe ? miso : !miso};
         end
         half();
         sck = 1'b0;
      end
      half();
      ss_n = 1'b1;
      in_write = 1'b0;
      repeat (6) @(posedge clk);
      #1;
   endtask

   // remembers any drive of miso during a write frame
   always @(posedge clk) begin
      if (in_write && miso_oe) begin
         oe_in_write <= 1'b1;
      end
   end
endmodule // eqc_spi_host

//--- eqc_equalizer_control_tb_top.sv
// self-checking bench of the equalizer control block
`timescale 1ns/10ps
module eqc_equalizer_control_tb_top;
   import eqc_pkg::*;
   localparam int PD_SIM = 20;
   logic clk, resetn, sck, ss_n, mosi, miso, miso_oe, spi_en, bypass, mute_r, tie, auto_sleep;
   logic signal_detect, carrier_present_n, filter_en, dc_restore_en, output_muted, powered_down;
   logic launch_coarse, extended_reach;
   logic [2:0] output_swing, offset_voltage;
   logic [3:0] launch_fine;
   logic [4:0] cable_length;
   logic [1:0] equalized_in, equalized_output_pair, code;
   logic [7:0] rd, d, aux;
   int mismatches, tests_run, cycles, seed;
   wire logic mute_w = tie ? carrier_present_n : mute_r;
   wire logic [4:0] path = {dc_restore_en, filter_en, output_muted, equalized_output_pair};

   eqc_equalizer_control #(.PD_CYCLES_P(PD_SIM)) i_dut (.clk(clk), .resetn(resetn),
      .sck(sck), .ss_n(ss_n), .mosi(mosi), .miso(miso), .miso_oe(miso_oe), .spi_en(spi_en),
      .bypass(bypass), .mute(mute_w), .auto_sleep(auto_sleep), .signal_detect(signal_detect),
      .cable_length(cable_length), .equalized_in(equalized_in),
      .carrier_present_n(carrier_present_n), .equalized_output_pair(equalized_output_pair),
      .filter_en(filter_en), .dc_restore_en(dc_restore_en), .output_muted(output_muted),
      .powered_down(powered_down), .output_swing(output_swing), .offset_voltage(offset_voltage),
      .launch_coarse(launch_coarse), .launch_fine(launch_fine), .extended_reach(extended_reach));
   eqc_spi_host i_host (.clk(clk), .sck(sck), .ss_n(ss_n), .mosi(mosi), .miso(miso),
      .miso_oe(miso_oe));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 40000) begin
         mismatches++;
         conclude();
      end
   end

   //----------------------------------------------------------------------
   // helpers
   //----------------------------------------------------------------------
   function automatic logic [4:0] exp_path(input logic byp, mt, slp, input logic [1:0] din);
      logic en;
      en = !slp && !(byp && !mt);
      return {en, en, mt && !slp, (mt || slp) ? 2'h0 : din};
   endfunction
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wr(input logic [6:0] a, input logic [7:0] v);
      i_host.xfer({1'b0, a, v}, 16, rd);
   endtask
   task automatic rd_chk(input logic [6:0] a, input logic [7:0] e);
      i_host.xfer({1'b1, a, 8'h00}, 16, rd);
      check(rd, e);
   endtask
   task automatic wait_pd(input logic v, input int lim);
      int n;
      n = 0;
      while (powered_down !== v && n < lim) begin
         step(1);
         n++;
      end
      check(powered_down, v);
   endtask
   task automatic conclude();
      $display("mismatches %0d tests_run %0d", mismatches, tests_run);
      if (mismatches == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   //----------------------------------------------------------------------
   // main sequence
   //----------------------------------------------------------------------
   initial begin
      seed = 32'h17542e66;
      {mismatches, tests_run, cycles} = '0;
      {resetn, spi_en, bypass, mute_r, tie, auto_sleep} = '0;
      signal_detect = 1'b1;
      cable_length = 5'($random(seed));
      equalized_in = 2'h0;
      step(4);
      resetn = 1'b1;
      step(6);
      for (int k = 0; k < 4; k++) begin
         {bypass, mute_r} = k[1:0];
         equalized_in = 2'($random(seed));
         step(6);
         check(path, exp_path(bypass, mute_r, 1'b0, equalized_in));
      end
      {bypass, mute_r} = 2'h0;
      check(carrier_present_n, 1'b0);
      signal_detect = 1'b0;
      tie = 1'b1;
      step(PD_SIM + 40);
      check({carrier_present_n, output_muted, powered_down}, 3'h6);
      tie = 1'b0;
      signal_detect = 1'b1;
      auto_sleep = 1'b1;
      step(6);
      signal_detect = 1'b0;
      {bypass, mute_r} = 2'h3;
      wait_pd(1'b1, PD_SIM + 12);
      check(path, exp_path(1'b1, 1'b1, 1'b1, equalized_in));
      signal_detect = 1'b1;
      wait_pd(1'b0, 100);
      {auto_sleep, bypass, mute_r} = 3'h0;
      spi_en = 1'b1;
      step(6);
      rd_chk(ADDR_GENERAL, 8'h88);
      rd_chk(ADDR_DRIVER, 8'h64);
      rd_chk(ADDR_LAUNCH, 8'h00);
      rd_chk(ADDR_AUX, 8'h00);
      rd_chk(7'h05, 8'h00);
      i_host.xfer({1'b1, ADDR_CABLE, 8'h00}, 16, rd);
      check(rd[7:3], cable_length);
      for (int k = 0; k < 4; k++) begin
         aux = 8'($random(seed));
         wr(ADDR_AUX, aux);
         rd_chk(ADDR_AUX, aux);
      end
      i_host.xfer({1'b0, ADDR_AUX, ~aux}, 12, rd);
      rd_chk(ADDR_AUX, aux);
      d = 8'($random(seed));
      wr(ADDR_DRIVER, d);
      check({output_swing, offset_voltage}, d[7:2]);
      rd_chk(ADDR_DRIVER, {d[7:2], 2'h0});
      wr(ADDR_LAUNCH, d);
      check({launch_coarse, launch_fine}, d[7:3]);
      check(i_host.oe_in_write, 1'b0);
      for (int k = 0; k < 4; k++) begin
         code = k[1:0];
         wr(ADDR_GENERAL, {3'h0, code, d[k], 2'h0});
         step(6);
         check({powered_down, extended_reach}, {code == SLEEP_FORCE, d[k]});
         signal_detect = 1'b0;
         step(PD_SIM + 30);
         check(powered_down, code == SLEEP_AUTO || code == SLEEP_FORCE);
         signal_detect = 1'b1;
         step(10);
      end
      wr(ADDR_GENERAL, 8'h20);
      step(6);
      check(path, exp_path(1'b1, 1'b0, 1'b0, equalized_in));
      wr(ADDR_GENERAL, 8'h40);
      step(6);
      check(output_muted, 1'b1);
      spi_en = 1'b0;
      step(6);
      check(output_muted, 1'b0);
      conclude();
   end
endmodule // eqc_equalizer_control_tb_top
